// [verilog/mac_regs_pkg.sv]
package mac_regs_pkg;

   // register byte offsets
   localparam logic [7:0] CFG_OFF  = 8'h00;
   localparam logic [7:0] STAT_OFF      = 8'h24;
   localparam logic [7:0] UNMASK_OFF    = 8'h28;
   localparam logic [7:0] MASK_SET_OFF  = 8'h2c;
   localparam logic [7:0] MASK_OFF      = 8'h30;
   localparam logic [7:0] MAINT_OFF     = 8'h34;
   localparam logic [7:0] PAUSE_T_OFF   = 8'h38;
   localparam logic [7:0] PAUSE_CNT_OFF = 8'h3c;
   localparam logic [7:0] TXOK_OFF      = 8'h40;

   // interrupt status bit positions
   localparam int IRQ_W          = 14;
   localparam int MGMT_DONE_IRQ  = 0;
   localparam int RX_DONE_IRQ    = 1;
   localparam int RX_USED_IRQ    = 2;
   localparam int TX_USED_IRQ    = 3;
   localparam int TX_UNDER_IRQ   = 4;
   localparam int RETRY_IRQ      = 5;
   localparam int TX_EXHAUST_IRQ = 6;
   localparam int TX_DONE_IRQ    = 7;
   localparam int RX_OVR_IRQ     = 10;
   localparam int BUS_ERR_IRQ    = 11;
   localparam int PAUSE_RX_IRQ   = 12;
   localparam int PAUSE_ZERO_IRQ = 13;
   localparam logic [IRQ_W-1:0] MASK_RESET = 14'h3fff;

   // config register bits
   localparam int CFG_W        = 3;
   localparam int CFG_SPEED100 = 0;
   localparam int CFG_BIG      = 1;
   localparam int CFG_JUMBO    = 2;

   // maintenance frame fields
   localparam int MAINT_OP_HI  = 29;
   localparam int MAINT_OP_LO  = 28;
   localparam int MAINT_DATA_W = 16;
   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [5:0] TA_FIRST_BIT   = 6'h2e;
   localparam logic [5:0] DATA_FIRST_BIT = 6'h30;
   localparam logic [5:0] LAST_BIT       = 6'h3f;

   // counter widths
   localparam int PAUSE_T_W   = 16;
   localparam int PAUSE_CNT_W = 16;
   localparam int TXOK_W      = 24;

   // frame length limits, bytes
   localparam int LEN_W = 14;
   localparam logic [LEN_W-1:0] LEN_MIN       = 14'h0040;
   localparam logic [LEN_W-1:0] LEN_MAX_STD   = 14'h05ee;
   localparam logic [LEN_W-1:0] LEN_MAX_BIG   = 14'h0600;
   localparam logic [LEN_W-1:0] LEN_MAX_JUMBO = 14'h2800;

   // pause quantum timing
   localparam int CLK_PERIOD_NS  = 20;
   localparam int BIT_NS_FAST    = 10;
   localparam int BIT_NS_SLOW    = 100;
   localparam int PAUSE_BITS     = 512;
   localparam int PRE_W          = 12;
   localparam int PAUSE_CYC_FAST = (PAUSE_BITS * BIT_NS_FAST
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PAUSE_CYC_SLOW = (PAUSE_BITS * BIT_NS_SLOW
                                    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [0:0] {
      MDIO_IDLE  = 1'b0,
      MDIO_SHIFT = 1'b1
   } mdio_state_e;

   typedef struct packed {
      logic bus_error;
      logic tx_done;
      logic tx_exhaust;
      logic retry_limit;
      logic tx_late_fetch;
      logic tx_used_mid;
      logic tx_qptr_write;
      logic tx_used_desc;
      logic rx_used_desc;
      logic rx_done;
   } mac_events_s;

   typedef struct packed {
      logic             valid;
      logic [LEN_W-1:0] length;
      logic             fcs_err;
      logic             align_err;
      logic             symbol_err;
   } pause_rx_s;

endpackage

// [verilog/mac_irq_mgmt_stats.sv]
`timescale 1ns/1ps
// Operation
// - bus error sets status bit 11
// - receive overrun flag rising sets bit 10
// - finished transmit sets bit 7
// - buffers exhausted mid frame sets bit 6
// - four underrun causes set bit 4
// - used descriptor read sets bit 3/2
// - frame stored in memory sets bit 1
// - management frame finished sets bit 0
// - reading status clears all status bits except those set in the same cycle
// - retry limit exceeded sets bit 5
// - enable write one clears mask bit
// - disable write one sets mask bit
// - mask readable, resets all disabled
// - op 10 read, 01 write
// - data field sent, or read result stored
// - pause time decrements every 512 bits
// - count good pause frames, length limits
// - count frames sent without underrun/retry
// - pause time reaching zero sets bit 13
module mac_irq_mgmt_stats #(
   parameter int MDC_HALF = 16
) (
   input  wire logic                      ref_clk_in,
   input  wire logic                      resetn_in,
   input  wire logic [7:0]                reg_addr_in,
   input  wire logic [31:0]               reg_wdata_in,
   input  wire logic                      reg_wr_in,
   input  wire logic                      reg_rd_in,
   output logic      [31:0]               reg_rdata_out,
   input  wire mac_regs_pkg::mac_events_s events_in,
   input  wire logic                      rx_status_overrun_in,
   input  wire mac_regs_pkg::pause_rx_s   pause_rx_in,
   input  wire logic                      mdio_in,
   output logic                           mdc_out,
   output logic                           mdio_out,
   output logic                           mdio_oe_out,
   output logic                           mgmt_busy_out,
   output logic                           irq_out
);

   localparam int DIV_W = $clog2(MDC_HALF + 1);

   generate
      if (MDC_HALF < 1) begin : g_bad_div
         $error("MDC_HALF must be at least 1");
      end
   endgenerate

   localparam int IW = mac_regs_pkg::IRQ_W;

   // register state
   logic [31:0]                        rdata_reg;
   logic [mac_regs_pkg::CFG_W-1:0]     cfg_reg;
   logic [IW-1:0]                      stat_reg;
   logic [IW-1:0]                      mask_reg;
   logic                               irq_reg;
   logic [31:0]                        maint_reg;
   logic [mac_regs_pkg::PAUSE_T_W-1:0] pause_reg;
   logic [mac_regs_pkg::PRE_W-1:0]     pre_reg;
   logic [mac_regs_pkg::PAUSE_CNT_W-1:0] pcnt_reg;
   logic [mac_regs_pkg::TXOK_W-1:0]    txok_reg;
   logic                               ovr_d_reg;
   // management link state
   mac_regs_pkg::mdio_state_e          state_reg;
   logic [DIV_W-1:0]                   div_reg;
   logic [5:0]                         idx_reg;
   logic                               mdc_reg;
   logic                               mdo_reg;
   logic                               oe_reg;
   logic [15:0]                        rd_shift_reg;
   logic                               mdi_s1_reg;
   logic                               mdi_s2_reg;

   // address decode
   wire sel_cfg = reg_addr_in == mac_regs_pkg::CFG_OFF;
   wire sel_stat   = reg_addr_in == mac_regs_pkg::STAT_OFF;
   wire sel_unmask = reg_addr_in == mac_regs_pkg::UNMASK_OFF;
   wire sel_mskset = reg_addr_in == mac_regs_pkg::MASK_SET_OFF;
   wire sel_mask   = reg_addr_in == mac_regs_pkg::MASK_OFF;
   wire sel_maint  = reg_addr_in == mac_regs_pkg::MAINT_OFF;
   wire sel_pause  = reg_addr_in == mac_regs_pkg::PAUSE_T_OFF;
   wire sel_pcnt   = reg_addr_in == mac_regs_pkg::PAUSE_CNT_OFF;
   wire sel_txok   = reg_addr_in == mac_regs_pkg::TXOK_OFF;

   wire cfg_wr    = reg_wr_in && sel_cfg;
   wire stat_rd   = reg_rd_in && sel_stat;
   wire unmask_wr = reg_wr_in && sel_unmask;
   wire mskset_wr = reg_wr_in && sel_mskset;
   wire pause_wr  = reg_wr_in && sel_pause;
   wire pcnt_wr   = reg_wr_in && sel_pcnt;
   wire txok_wr   = reg_wr_in && sel_txok;
   // a new frame is only accepted while the link is idle
   wire maint_wr = reg_wr_in && sel_maint &&
                   state_reg == mac_regs_pkg::MDIO_IDLE;

   wire [IW-1:0] wr_bits = reg_wdata_in[IW-1:0];

   // read mux; unmapped and write-only offsets read zero
   wire [31:0] rd_mux =
      sel_cfg   ? {{(32-mac_regs_pkg::CFG_W){1'b0}}, cfg_reg} :
      sel_stat  ? {{(32-IW){1'b0}}, stat_reg} :
      sel_mask  ? {{(32-IW){1'b0}}, mask_reg} :
      sel_maint ? maint_reg :
      sel_pause ? {16'h0000, pause_reg} :
      sel_pcnt  ? {16'h0000, pcnt_reg} :
      sel_txok  ? {8'h00, txok_reg} :
      32'h0000_0000;

   // management frame sequencing
   wire is_read  =
      maint_reg[mac_regs_pkg::MAINT_OP_HI:mac_regs_pkg::MAINT_OP_LO]
      == mac_regs_pkg::OP_READ;
   wire shifting = state_reg == mac_regs_pkg::MDIO_SHIFT;
   wire div_tick = shifting && div_reg == DIV_W'(MDC_HALF - 1);
   wire rise     = div_tick && !mdc_reg;
   wire fall     = div_tick && mdc_reg;
   wire finish   = fall && idx_reg == mac_regs_pkg::LAST_BIT;
   wire [5:0] idx_inc = idx_reg + 6'h01;
   // 32 preamble ones, then the register contents msb first
   wire next_bit = idx_inc[5] ? maint_reg[~idx_inc[4:0]] : 1'b1;
   // release the line from the turnaround on for reads
   wire next_oe  = !(is_read && idx_inc >= mac_regs_pkg::TA_FIRST_BIT);
   wire capture  = rise && is_read &&
                   idx_reg >= mac_regs_pkg::DATA_FIRST_BIT;
   wire [15:0] rd_shift_next = {rd_shift_reg[14:0], mdi_s2_reg};

   // pause timer prescaler: one tick per 512 bit times
   wire [mac_regs_pkg::PRE_W-1:0] pre_last =
      cfg_reg[mac_regs_pkg::CFG_SPEED100] ?
      mac_regs_pkg::PRE_W'(mac_regs_pkg::PAUSE_CYC_FAST - 1) :
      mac_regs_pkg::PRE_W'(mac_regs_pkg::PAUSE_CYC_SLOW - 1);
   wire pause_nz   = pause_reg != '0;
   wire pause_tick = pause_nz && pre_reg == pre_last;
   wire pause_zero = pause_tick && !pause_wr &&
                     pause_reg == mac_regs_pkg::PAUSE_T_W'(1);

   // good pause frame qualification
   wire [mac_regs_pkg::LEN_W-1:0] len_max =
      cfg_reg[mac_regs_pkg::CFG_JUMBO] ? mac_regs_pkg::LEN_MAX_JUMBO :
      cfg_reg[mac_regs_pkg::CFG_BIG]   ? mac_regs_pkg::LEN_MAX_BIG   :
      mac_regs_pkg::LEN_MAX_STD;
   wire pause_good = pause_rx_in.valid &&
                     pause_rx_in.length >= mac_regs_pkg::LEN_MIN &&
                     pause_rx_in.length <= len_max &&
                     !pause_rx_in.fcs_err && !pause_rx_in.align_err &&
                     !pause_rx_in.symbol_err;

   // transmit outcome
   wire tx_underrun = events_in.tx_late_fetch || events_in.bus_error ||
                      events_in.tx_used_mid ||
                      events_in.tx_qptr_write;
   wire tx_ok = events_in.tx_done && !tx_underrun &&
                !events_in.retry_limit;
   wire ovr_rise = rx_status_overrun_in && !ovr_d_reg;

   // status set vector
   logic [IW-1:0] irq_set;
   always_comb begin
      irq_set = '0;
      irq_set[mac_regs_pkg::MGMT_DONE_IRQ]  = finish;
      irq_set[mac_regs_pkg::RX_DONE_IRQ]    = events_in.rx_done;
      irq_set[mac_regs_pkg::RX_USED_IRQ]    = events_in.rx_used_desc;
      irq_set[mac_regs_pkg::TX_USED_IRQ]    = events_in.tx_used_desc;
      irq_set[mac_regs_pkg::TX_UNDER_IRQ]   = tx_underrun;
      irq_set[mac_regs_pkg::RETRY_IRQ]      = events_in.retry_limit;
      irq_set[mac_regs_pkg::TX_EXHAUST_IRQ] = events_in.tx_exhaust;
      irq_set[mac_regs_pkg::TX_DONE_IRQ]    = events_in.tx_done;
      irq_set[mac_regs_pkg::RX_OVR_IRQ]     = ovr_rise;
      irq_set[mac_regs_pkg::BUS_ERR_IRQ]    = events_in.bus_error;
      irq_set[mac_regs_pkg::PAUSE_RX_IRQ]   = pause_good;
      irq_set[mac_regs_pkg::PAUSE_ZERO_IRQ] = pause_zero;
   end

   // set wins over the clear-on-read so no event is lost
   wire [IW-1:0] stat_next = (stat_rd ? '0 : stat_reg) | irq_set;
   wire [IW-1:0] mask_next =
      (mask_reg & ~(unmask_wr ? wr_bits : '0)) |
      (mskset_wr ? wr_bits : '0);

   // bus slave and interrupt registers
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdata_reg <= 32'h0000_0000;
         cfg_reg   <= '0;
         stat_reg  <= '0;
         mask_reg  <= mac_regs_pkg::MASK_RESET;
         irq_reg   <= 1'b0;
         ovr_d_reg <= 1'b0;
      end else begin
         rdata_reg <= reg_rd_in ? rd_mux : 32'h0000_0000;
         if (cfg_wr) begin
            cfg_reg <= reg_wdata_in[mac_regs_pkg::CFG_W-1:0];
         end
         stat_reg  <= stat_next;
         mask_reg  <= mask_next;
         irq_reg   <= |(stat_reg & ~mask_reg);
         ovr_d_reg <= rx_status_overrun_in;
      end
   end

   // pause timer and statistics counters; software writes win
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pause_reg <= '0;
         pre_reg   <= '0;
         pcnt_reg  <= '0;
         txok_reg  <= '0;
      end else begin
         if (pause_wr) begin
            pause_reg <= reg_wdata_in[mac_regs_pkg::PAUSE_T_W-1:0];
         end else if (pause_tick) begin
            pause_reg <= pause_reg - mac_regs_pkg::PAUSE_T_W'(1);
         end
         if (pause_wr || !pause_nz || pause_tick) begin
            pre_reg <= '0;
         end else begin
            pre_reg <= pre_reg + mac_regs_pkg::PRE_W'(1);
         end
         if (pcnt_wr) begin
            pcnt_reg <= reg_wdata_in[mac_regs_pkg::PAUSE_CNT_W-1:0];
         end else if (pause_good) begin
            pcnt_reg <= pcnt_reg + mac_regs_pkg::PAUSE_CNT_W'(1);
         end
         if (txok_wr) begin
            txok_reg <= reg_wdata_in[mac_regs_pkg::TXOK_W-1:0];
         end else if (tx_ok) begin
            txok_reg <= txok_reg + mac_regs_pkg::TXOK_W'(1);
         end
      end
   end

   // maintenance register: loaded by software, read data returned
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         maint_reg <= 32'h0000_0000;
      end else if (maint_wr) begin
         maint_reg <= reg_wdata_in;
      end else if (finish && is_read) begin
         // all 16 bits were captured at the rises; no extra shift here
         maint_reg[mac_regs_pkg::MAINT_DATA_W-1:0] <= rd_shift_reg;
      end
   end

   // the data pin arrives from outside: two flops before use
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mdi_s1_reg <= 1'b0;
         mdi_s2_reg <= 1'b0;
      end else begin
         mdi_s1_reg <= mdio_in;
         mdi_s2_reg <= mdi_s1_reg;
      end
   end

   // serial engine: bits change on the falling clock, read on rising
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg    <= mac_regs_pkg::MDIO_IDLE;
         div_reg      <= '0;
         idx_reg      <= '0;
         mdc_reg      <= 1'b0;
         mdo_reg      <= 1'b0;
         oe_reg       <= 1'b0;
         rd_shift_reg <= '0;
      end else begin
         case (state_reg)
            mac_regs_pkg::MDIO_IDLE: begin
               if (maint_wr) begin
                  state_reg <= mac_regs_pkg::MDIO_SHIFT;
                  div_reg   <= '0;
                  idx_reg   <= '0;
                  mdo_reg   <= 1'b1;
                  oe_reg    <= 1'b1;
               end
            end
            mac_regs_pkg::MDIO_SHIFT: begin
               div_reg <= div_tick ? '0 : div_reg + DIV_W'(1);
               if (rise) begin
                  mdc_reg <= 1'b1;
               end
               if (capture) begin
                  rd_shift_reg <= rd_shift_next;
               end
               if (finish) begin
                  state_reg <= mac_regs_pkg::MDIO_IDLE;
                  mdc_reg   <= 1'b0;
                  mdo_reg   <= 1'b0;
                  oe_reg    <= 1'b0;
               end else if (fall) begin
                  mdc_reg <= 1'b0;
                  idx_reg <= idx_inc;
                  mdo_reg <= next_bit;
                  oe_reg  <= next_oe;
               end
            end
            default: begin
               state_reg <= mac_regs_pkg::MDIO_IDLE;
            end
         endcase
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign mdc_out       = mdc_reg;
   assign mdio_out      = mdo_reg;
   assign mdio_oe_out   = oe_reg;
   assign mgmt_busy_out = state_reg;
   assign irq_out       = irq_reg;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   property p_isr_read_clear;
      (stat_rd && irq_set == '0) |=> stat_reg == '0;
   endproperty
   a_isr_read_clear: assert property (p_isr_read_clear)
      else $error("status not cleared by read");

   property p_tx_done_sets;
      events_in.tx_done |=> stat_reg[mac_regs_pkg::TX_DONE_IRQ];
   endproperty
   a_tx_done_sets: assert property (p_tx_done_sets)
      else $error("transmit done bit not set");

   property p_unmask;
      (unmask_wr && !mskset_wr) |=> (mask_reg & $past(wr_bits)) == '0;
   endproperty
   a_unmask: assert property (p_unmask)
      else $error("enable write did not clear mask");

   property p_mask;
      mskset_wr |=> (mask_reg & $past(wr_bits)) == $past(wr_bits);
   endproperty
   a_mask: assert property (p_mask)
      else $error("disable write did not set mask");

   property p_irq_follows;
      ##1 irq_out == $past(|(stat_reg & ~mask_reg));
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("irq output does not follow status and mask");

   property p_pause_dec;
      (pause_tick && !pause_wr) |=> pause_reg == $past(pause_reg) - 16'h0001;
   endproperty
   a_pause_dec: assert property (p_pause_dec)
      else $error("pause time not decremented");

   property p_pause_zero;
      pause_zero |=> pause_reg == '0 &&
                     stat_reg[mac_regs_pkg::PAUSE_ZERO_IRQ];
   endproperty
   a_pause_zero: assert property (p_pause_zero)
      else $error("pause zero status not set");

   property p_tx_ok;
      (tx_ok && !txok_wr) |=> txok_reg == $past(txok_reg) + 24'h00_0001;
   endproperty
   a_tx_ok: assert property (p_tx_ok)
      else $error("transmit ok counter not incremented");

   property p_pause_count;
      (pause_rx_in.valid && pause_rx_in.fcs_err && !pcnt_wr) |=>
         $stable(pcnt_reg);
   endproperty
   a_pause_count: assert property (p_pause_count)
      else $error("bad pause frame counted");

   sequence s_frame_start;
      maint_wr ##1 (shifting && mdio_oe_out && mdio_out);
   endsequence
   sequence s_last_edge;
      shifting && finish;
   endsequence

   property p_frame_start;
      maint_wr |-> s_frame_start;
   endproperty
   a_frame_start: assert property (p_frame_start)
      else $error("management frame did not start");

   property p_mgmt_done;
      s_last_edge |=> stat_reg[mac_regs_pkg::MGMT_DONE_IRQ] &&
                      !mgmt_busy_out && !mdio_oe_out;
   endproperty
   a_mgmt_done: assert property (p_mgmt_done)
      else $error("management done not flagged");

   property p_read_data;
      (s_last_edge and (is_read && !maint_wr)) |=>
         maint_reg[15:0] == $past(rd_shift_reg);
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read data not stored");

endmodule

// [test/phy_model.sv]
`timescale 1ns/1ps
// far side of the management link; the line has a pull-up in the bench
module phy_model (
   input  wire logic        mdc_in,
   input  wire logic        mdio_in,
   input  wire logic [15:0] rd_data_in,
   output logic             oe_out,
   output logic             d_out,
   output logic [31:0]      frame_out
);
   int          cnt = 0;
   logic [63:0] sh  = '0;
   logic        rd  = 1'b0;
   initial oe_out = 1'b0;
   initial d_out = 1'b1;
   initial frame_out = '0;
   always @(posedge mdc_in) begin
      sh = {sh[62:0], mdio_in};
      cnt = (cnt == 63) ? 0 : cnt + 1;
      // op field sits in frame bits 34..35
      if (cnt == 36) rd = (sh[1:0] == 2'b10);
      if (cnt == 0) frame_out = sh[31:0];
   end
   // data changes at mdc fall, a full half period before the next rise
   always @(negedge mdc_in) begin
      oe_out = rd && cnt >= 47;
      d_out = (cnt > 47) ? rd_data_in[4'(63 - cnt)] : 1'b0;
   end
endmodule

// [test/test_mac_irq_mgmt_stats.sv]
`timescale 1ns/1ps
module test_mac_irq_mgmt_stats;
   logic                      ref_clk_in = 1'b0;
   logic                      resetn_in  = 1'b0;
   logic [7:0]                addr       = '0;
   logic [31:0]               wdata      = '0;
   logic                      wr         = 1'b0;
   logic                      rd         = 1'b0;
   logic [31:0]               rdata;
   mac_regs_pkg::mac_events_s ev         = '0;
   logic                      ovr        = 1'b0;
   mac_regs_pkg::pause_rx_s   pr         = '0;
   logic                      mdc, mdo, mdoe, busy, irq, phy_oe, phy_d;
   logic                      line;
   logic [31:0]               frame;
   logic [15:0]               phy_val    = 16'hbeef;
   logic [31:0]               v;
   int                        error_cnt  = 0;
   int                        n_compared = 0;
   int                        cyc        = 0;
   // pull-up wins when nobody drives
   assign line = mdoe ? mdo : (phy_oe ? phy_d : 1'b1);
   always #10 ref_clk_in = ~ref_clk_in;

   mac_irq_mgmt_stats #(.MDC_HALF(4)) u_dut (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .events_in(ev), .rx_status_overrun_in(ovr),
      .pause_rx_in(pr), .mdio_in(line), .mdc_out(mdc), .mdio_out(mdo),
      .mdio_oe_out(mdoe), .mgmt_busy_out(busy), .irq_out(irq));
   phy_model u_phy (.mdc_in(mdc), .mdio_in(line), .rd_data_in(phy_val),
      .oe_out(phy_oe), .d_out(phy_d), .frame_out(frame));

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk_in);
      wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input string n);
      @(posedge ref_clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk_in);
      rd <= 1'b0;
      #1 chk(n, rdata, e);
   endtask
   task automatic pulse(input logic [9:0] e);
      @(posedge ref_clk_in);
      ev <= mac_regs_pkg::mac_events_s'(e);
      @(posedge ref_clk_in);
      ev <= '0;
   endtask
   task automatic mgmt_wait;
      #1 chk("busy", {31'h0, busy}, 32'h1);
      repeat (1000) begin
         @(posedge ref_clk_in);
         if (busy === 1'b0) break;
      end
   endtask

   initial begin
      int          pos[10] = '{1, 2, 3, 4, 4, 4, 5, 6, 7, 11};
      logic [7:0]  offs[7] = '{8'h34, 8'h38, 8'h3c, 8'h40, 8'h24, 8'h28,
                               8'h7c};
      logic [9:0]  bad[3]  = '{10'h140, 10'h120, 10'h300};
      logic [2:0]  pcfg[12] = '{0, 0, 0, 0, 0, 0, 0, 2, 2, 4, 4, 6};
      logic [2:0]  perr[12] = '{0, 0, 0, 0, 4, 2, 1, 0, 0, 0, 0, 0};
      logic [13:0] plen[12] = '{14'h003f, 14'h0040, 14'h05ee, 14'h05ef,
         14'h0064, 14'h0064, 14'h0064, 14'h0600, 14'h0601, 14'h2800,
         14'h2801, 14'h2800};
      logic [31:0] pcnt = '0;
      logic [13:0] lmax;
      logic [31:0] mw, mr;
      repeat (6) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      rc(8'h30, 32'h0000_3fff, "mask_reset");
      foreach (offs[i]) rc(offs[i], '0, "reset_zero");
      $display("test reset done");
      wr32(8'h28, 32'h0000_0081);
      rc(8'h30, 32'h0000_3f7e, "unmask");
      wr32(8'h28, '0);
      wr32(8'h2c, '0);
      rc(8'h30, 32'h0000_3f7e, "zero_write");
      wr32(8'h2c, 32'h0000_0001);
      rc(8'h30, 32'h0000_3f7f, "mask");
      wr32(8'h28, 32'h0000_3fff);
      rc(8'h30, '0, "unmask_all");
      $display("test mask done");
      for (int i = 0; i < 10; i++) begin
         pulse(10'h1 << i);
         @(posedge ref_clk_in);
         #1 chk("irq", {31'h0, irq}, 32'h1);
         rc(8'h24, (32'h1 << pos[i]) | (i == 9 ? 32'h10 : 32'h0),
            "event_bit");
         rc(8'h24, '0, "clear_on_read");
      end
      @(posedge ref_clk_in);
      #1 chk("irq_clear", {31'h0, irq}, 32'h0);
      @(posedge ref_clk_in);
      ovr <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      rc(8'h24, 32'h0000_0400, "overrun");
      rc(8'h24, '0, "overrun_level");
      ovr <= 1'b0;
      $display("test events done");
      foreach (bad[i]) pulse(bad[i]);
      rc(8'h40, 32'h1, "tx_ok");
      rc(8'h24, 32'h0000_08b0, "tx_status");
      wr32(8'h40, 32'h0000_ffff);
      pulse(10'h100);
      rc(8'h40, 32'h0001_0000, "tx_ok_carry");
      wr32(8'h2c, 32'h0000_0080);
      pulse(10'h100);
      repeat (2) @(posedge ref_clk_in);
      #1 chk("irq_masked", {31'h0, irq}, 32'h0);
      rc(8'h24, 32'h0000_0080, "masked_status");
      $display("test tx done");
      foreach (plen[i]) begin
         wr32(8'h00, {29'h0, pcfg[i]});
         lmax = pcfg[i][2] ? 14'h2800 : (pcfg[i][1] ? 14'h0600 : 14'h05ee);
         if (perr[i] == 0 && plen[i] >= 14'h0040 && plen[i] <= lmax) pcnt++;
         @(posedge ref_clk_in);
         pr <= {1'b1, plen[i], perr[i]};
         @(posedge ref_clk_in);
         pr <= '0;
         rc(8'h3c, pcnt, "pause_count");
      end
      rc(8'h24, 32'h0000_1000, "pause_status");
      $display("test pause frames done");
      wr32(8'h00, 32'h1);
      wr32(8'h38, 32'h2);
      repeat (200) @(posedge ref_clk_in);
      rc(8'h38, 32'h2, "pause_hold");
      repeat (100) @(posedge ref_clk_in);
      rc(8'h38, 32'h1, "pause_step");
      repeat (256) @(posedge ref_clk_in);
      rc(8'h38, 32'h0, "pause_zero");
      rc(8'h24, 32'h0000_2000, "pause_zero_bit");
      $display("test pause timer done");
      mw = {2'b01, 2'b01, 5'h03, 5'h04, 2'b10, 16'ha5c3};
      wr32(8'h34, mw);
      mgmt_wait();
      chk("frame_wr", frame, mw);
      rc(8'h24, 32'h1, "mgmt_done");
      mr = {2'b01, 2'b10, 5'h1d, 5'h02, 2'b10, 16'h0000};
      wr32(8'h34, mr);
      wr32(8'h34, 32'hffff_ffff);
      mgmt_wait();
      chk("frame_rd", frame, {mr[31:16], phy_val});
      rc(8'h34, {mr[31:16], phy_val}, "read_data");
      rc(8'h24, 32'h1, "mgmt_done_rd");
      $display("test management done");
      tally_and_finish();
   end
endmodule
